// ### rtl/ioru_pkg.sv
// Package: constants, types and register map for the OR instruction unit
package ioru_pkg;

    // ------------------------------------------------------------
    // Register map (word-aligned byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] IORU_ADR_INSTR   = 8'h00;
    localparam logic [7:0] IORU_ADR_CTRL    = 8'h04;
    localparam logic [7:0] IORU_ADR_WREG    = 8'h08;
    localparam logic [7:0] IORU_ADR_BANK    = 8'h0C;
    localparam logic [7:0] IORU_ADR_FSR2    = 8'h10;
    localparam logic [7:0] IORU_ADR_STATUS  = 8'h14;
    localparam logic [7:0] IORU_ADR_MEMADR  = 8'h18;
    localparam logic [7:0] IORU_ADR_MEMDAT  = 8'h1C;

    // ------------------------------------------------------------
    // Encodings and fields
    // ------------------------------------------------------------
    localparam logic [7:0]  IORU_OP_LIT     = 8'h09;
    localparam logic [5:0]  IORU_OP_FILE    = 6'h04;
    localparam int          IORU_D_BIT      = 9;
    localparam int          IORU_A_BIT      = 8;
    localparam logic [7:0]  IORU_IDX_LIMIT  = 8'h5F;
    localparam logic [7:0]  IORU_ACC_SPLIT  = 8'h60;
    localparam logic [3:0]  IORU_SFR_BANK   = 4'hF;
    localparam int          IORU_ST_N       = 1;
    localparam int          IORU_ST_Z       = 0;
    localparam int          IORU_CTRL_XINST = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  IORU_RST_BYTE   = 8'h00;
    localparam logic [3:0]  IORU_RST_BANK   = 4'h0;
    localparam logic [11:0] IORU_RST_FSR    = 12'h000;

    typedef enum logic [2:0] {
        IORU_IDLE   = 3'b000,
        IORU_DECODE = 3'b001,
        IORU_READ   = 3'b010,
        IORU_PROC   = 3'b011,
        IORU_WRITE  = 3'b100
    } ioru_phase_t;

    typedef struct packed {
        logic        is_lit;
        logic        to_file;
        logic [11:0] addr;
        logic [7:0]  literal;
    } ioru_decoded_t;

endpackage

// ### rtl/ioru_core.sv
// Top module: OR-literal and OR-file execution with Wishbone register access
//
// The implementer's own choices: the address map and the Wishbone slave port.
`timescale 1ns/10ps

module ioru_core
    import ioru_pkg::*;
#(
    parameter int MEM_DEPTH = 4096
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             busy_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]    mem_r [MEM_DEPTH];
    ioru_phase_t   phase_r,   phase_nxt;
    logic [15:0]   instr_r,   instr_nxt;
    ioru_decoded_t dec_r,     dec_nxt;
    logic [7:0]    wreg_r,    wreg_nxt;
    logic [3:0]    bank_r,    bank_nxt;
    logic [11:0]   fsr_r,     fsr_nxt;
    logic          xinst_r,   xinst_nxt;
    logic          flag_n_r,  flag_n_nxt;
    logic          flag_z_r,  flag_z_nxt;
    logic          illegal_r, illegal_nxt;
    logic [7:0]    opnd_r,    opnd_nxt;
    logic [7:0]    res_r,     res_nxt;
    logic [11:0]   madr_r,    madr_nxt;
    logic [31:0]   rdat_r,    rdat_nxt;
    logic          ack_r,     ack_nxt;
    logic          busy_r,    busy_nxt;
    logic          mem_we;
    logic [11:0]   mem_wa;
    logic [7:0]    mem_wd;

    // Resolve an 8-bit operand address to a 12-bit data address
    function automatic logic [11:0] resolve(input logic [7:0]  f,
                                            input logic        a,
                                            input logic        x,
                                            input logic [3:0]  bank_select_register,
                                            input logic [11:0] fsr);
        if (a) begin
            resolve = {bank_select_register, f};
        end else if (x && f <= IORU_IDX_LIMIT) begin
            resolve = fsr + {4'h0, f};
        end else if (f < IORU_ACC_SPLIT) begin
            resolve = {4'h0, f};
        end else begin
            resolve = {IORU_SFR_BANK, f};
        end
    endfunction

    function automatic logic byte_lane_ok(input logic [3:0] sel);
        byte_lane_ok = sel[0];
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic bus_req;
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;

    always_comb begin
        phase_nxt   = phase_r;
        instr_nxt   = instr_r;
        dec_nxt     = dec_r;
        wreg_nxt    = wreg_r;
        bank_nxt    = bank_r;
        fsr_nxt     = fsr_r;
        xinst_nxt   = xinst_r;
        flag_n_nxt  = flag_n_r;
        flag_z_nxt  = flag_z_r;
        illegal_nxt = illegal_r;
        opnd_nxt    = opnd_r;
        res_nxt     = res_r;
        madr_nxt    = madr_r;
        rdat_nxt    = rdat_r;
        ack_nxt     = 1'b0;
        mem_we      = 1'b0;
        mem_wa      = madr_r;
        mem_wd      = wb_dat_i[7:0];

        // Instruction cycle, one phase per clock
        case (phase_r)
            IORU_IDLE: begin
            end
            IORU_DECODE: begin
                dec_nxt.is_lit  = instr_r[15:8] == IORU_OP_LIT;
                dec_nxt.to_file = instr_r[IORU_D_BIT];
                dec_nxt.literal = instr_r[7:0];
                dec_nxt.addr    = resolve(instr_r[7:0],
                                          instr_r[IORU_A_BIT], xinst_r,
                                          bank_r, fsr_r);
                if (instr_r[15:8] == IORU_OP_LIT ||
                    instr_r[15:10] == IORU_OP_FILE) begin
                    illegal_nxt = 1'b0;
                    phase_nxt   = IORU_READ;
                end else begin
                    // Unsupported opcode retires, setting only the illegal flag
                    illegal_nxt = 1'b1;
                    phase_nxt   = IORU_IDLE;
                end
            end
            IORU_READ: begin
                opnd_nxt  = dec_r.is_lit ? dec_r.literal
                                         : mem_r[dec_r.addr];
                phase_nxt = IORU_PROC;
            end
            IORU_PROC: begin
                res_nxt   = wreg_r | opnd_r;
                phase_nxt = IORU_WRITE;
            end
            IORU_WRITE: begin
                flag_n_nxt = res_r[7];
                flag_z_nxt = res_r == IORU_RST_BYTE;
                if (!dec_r.is_lit && dec_r.to_file) begin
                    mem_we = 1'b1;
                    mem_wa = dec_r.addr;
                    mem_wd = res_r;
                end else begin
                    wreg_nxt = res_r;
                end
                phase_nxt = IORU_IDLE;
            end
            default: begin
                phase_nxt = IORU_IDLE;
            end
        endcase

        // Register bus; INSTR, W and MEMDAT writes are acked but dropped while an instruction runs
        if (bus_req) begin
            ack_nxt  = 1'b1;
            rdat_nxt = 32'h0000_0000;
            if (wb_adr_i == IORU_ADR_INSTR) begin
                rdat_nxt = {16'h0000, instr_r};
                if (wb_we_i && phase_r == IORU_IDLE) begin
                    if (wb_sel_i[0]) instr_nxt[7:0]  = wb_dat_i[7:0];
                    if (wb_sel_i[1]) instr_nxt[15:8] = wb_dat_i[15:8];
                    // Writing the high byte launches execution
                    if (wb_sel_i[1]) phase_nxt = IORU_DECODE;
                end
            end else if (wb_adr_i == IORU_ADR_CTRL) begin
                rdat_nxt = {31'h0, xinst_r};
                if (wb_we_i && byte_lane_ok(wb_sel_i))
                    xinst_nxt = wb_dat_i[IORU_CTRL_XINST];
            end else if (wb_adr_i == IORU_ADR_WREG) begin
                rdat_nxt = {24'h0, wreg_r};
                if (wb_we_i && byte_lane_ok(wb_sel_i) &&
                    phase_r == IORU_IDLE)
                    wreg_nxt = wb_dat_i[7:0];
            end else if (wb_adr_i == IORU_ADR_BANK) begin
                rdat_nxt = {28'h0, bank_r};
                if (wb_we_i && byte_lane_ok(wb_sel_i))
                    bank_nxt = wb_dat_i[3:0];
            end else if (wb_adr_i == IORU_ADR_FSR2) begin
                rdat_nxt = {20'h0, fsr_r};
                if (wb_we_i && byte_lane_ok(wb_sel_i))
                    fsr_nxt = wb_dat_i[11:0];
            end else if (wb_adr_i == IORU_ADR_STATUS) begin
                rdat_nxt = {28'h0, illegal_r, phase_r != IORU_IDLE,
                            flag_n_r, flag_z_r};
            end else if (wb_adr_i == IORU_ADR_MEMADR) begin
                rdat_nxt = {20'h0, madr_r};
                if (wb_we_i && byte_lane_ok(wb_sel_i))
                    madr_nxt = wb_dat_i[11:0];
            end else if (wb_adr_i == IORU_ADR_MEMDAT) begin
                rdat_nxt = {24'h0, mem_r[madr_r]};
                if (wb_we_i && byte_lane_ok(wb_sel_i) &&
                    phase_r == IORU_IDLE) begin
                    mem_we = 1'b1;
                    mem_wa = madr_r;
                    mem_wd = wb_dat_i[7:0];
                end
            end
        end

        // Registered so busy_o comes straight from a flip-flop
        busy_nxt = phase_nxt != IORU_IDLE;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_r   <= IORU_IDLE;
            instr_r   <= 16'h0000;
            dec_r     <= '0;
            wreg_r    <= IORU_RST_BYTE;
            bank_r    <= IORU_RST_BANK;
            fsr_r     <= IORU_RST_FSR;
            xinst_r   <= 1'b0;
            flag_n_r  <= 1'b0;
            flag_z_r  <= 1'b0;
            illegal_r <= 1'b0;
            opnd_r    <= IORU_RST_BYTE;
            res_r     <= IORU_RST_BYTE;
            madr_r    <= IORU_RST_FSR;
            rdat_r    <= 32'h0000_0000;
            ack_r     <= 1'b0;
            busy_r    <= 1'b0;
        end else begin
            phase_r   <= phase_nxt;
            instr_r   <= instr_nxt;
            dec_r     <= dec_nxt;
            wreg_r    <= wreg_nxt;
            bank_r    <= bank_nxt;
            fsr_r     <= fsr_nxt;
            xinst_r   <= xinst_nxt;
            flag_n_r  <= flag_n_nxt;
            flag_z_r  <= flag_z_nxt;
            illegal_r <= illegal_nxt;
            opnd_r    <= opnd_nxt;
            res_r     <= res_nxt;
            madr_r    <= madr_nxt;
            rdat_r    <= rdat_nxt;
            ack_r     <= ack_nxt;
            busy_r    <= busy_nxt;
        end
    end

    // Data memory has no reset, like real file registers
    always_ff @(posedge clk_i) begin
        if (mem_we)
            mem_r[mem_wa] <= mem_wd;
    end

    assign wb_dat_o = rdat_r;
    assign wb_ack_o = ack_r;
    assign busy_o   = busy_r;

endmodule

// ### test/ioru_chk.sv
// Checker: bus handshake and instruction timing of the OR unit
`timescale 1ns/10ps
module ioru_chk
    import ioru_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic        busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    logic go;
    logic rd_st;
    assign take  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign go    = take && wb_we_i && wb_adr_i == IORU_ADR_INSTR &&
                   wb_sel_i[1];
    // Opcode class of the run just launched; unsupported ones retire early
    logic legal_r;
    always_ff @(posedge clk_i) begin
        if (rst_i)
            legal_r <= 1'b0;
        else if (go && !busy_o)
            legal_r <= wb_dat_i[15:8] == IORU_OP_LIT ||
                       wb_dat_i[15:10] == IORU_OP_FILE;
    end
    assign rd_st = take && !wb_we_i && wb_adr_i == IORU_ADR_STATUS;
    property p_ack_next; take |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    property p_ack_why; wb_ack_o |-> $past(take); endproperty
    a_ack_why: assert property (p_ack_why) else $error("ack unasked");
    property p_start; go && !busy_o |=> busy_o; endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_four;
        $rose(busy_o) && legal_r |-> busy_o[*4] ##1 !busy_o;
    endproperty
    a_four: assert property (p_four) else $error("not 4 phases");
    property p_one;
        $rose(busy_o) && !legal_r |-> busy_o ##1 !busy_o;
    endproperty
    a_one: assert property (p_one) else $error("bad opcode ran on");
    property p_cause; $rose(busy_o) |-> $past(go); endproperty
    a_cause: assert property (p_cause) else $error("busy unasked");
    property p_hole;
        take && !wb_we_i && wb_adr_i > IORU_ADR_MEMDAT |=> wb_dat_o == 32'h0;
    endproperty
    a_hole: assert property (p_hole) else $error("hole not zero");
    property p_stbusy; rd_st |=> wb_dat_o[2] == $past(busy_o); endproperty
    a_stbusy: assert property (p_stbusy) else $error("busy bit");
    // An OR result cannot be both zero and negative
    property p_nz; rd_st |=> !(wb_dat_o[IORU_ST_N] && wb_dat_o[IORU_ST_Z]);
    endproperty
    a_nz: assert property (p_nz) else $error("N and Z");
endmodule
bind ioru_core ioru_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o));

// ### test/tb.sv
// Testbench: OR unit driven through its register bus
`timescale 1ns/10ps
module tb;
    import ioru_pkg::*;
    typedef struct packed {
        logic [15:0] ins;
        logic        ext;
        logic [3:0]  bank;
        logic [11:0] fsr, ea;
        logic [7:0]  w, mv, ew, em;
        logic [1:0]  nz;
    } ioru_row_t;
    logic        clk_i, rst_i, cyc, stb, we;
    logic [7:0]  adr;
    logic [3:0]  sel, bsel;
    logic [31:0] dat, rdat, q;
    logic        ack, busy;
    int          fails, num_checks;
    ioru_row_t   rows [9];
    ioru_core #(.MEM_DEPTH(4096)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .busy_o(busy));
    initial begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    // ------------------------------------------------------------
    // Bus cycle: request held until ack is seen at a rising edge
    // ------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, sel, adr, dat} <= {2'h3, w, bsel, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 20);
        q = rdat;
        {cyc, stb} <= 2'h0;
        if (ack !== 1'h1) begin
            fails++;
            give_verdict();
        end
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            bus(1'h0, IORU_ADR_STATUS, 32'h0);
            n++;
        end while (q[2] !== 1'h0 && n < 20);
        if (q[2] !== 1'h0) begin
            fails++;
            give_verdict();
        end
    endtask
    initial begin
        ioru_row_t r;
        {rst_i, cyc, stb, we, adr, dat, sel} = {1'h1, 43'h0, 4'hF};
        bsel = 4'hF;
        fails = 0;
        num_checks = 0;
        rows = '{
          '{16'h0935,1'h0,4'h0,12'h000,12'h000,8'h9A,8'h00,8'hBF,8'h00,2'h2},
          '{16'h0900,1'h0,4'h0,12'h000,12'h000,8'h00,8'h00,8'h00,8'h00,2'h1},
          '{16'h1120,1'h0,4'h3,12'h000,12'h320,8'h91,8'h13,8'h93,8'h13,2'h2},
          '{16'h13FF,1'h0,4'h5,12'h000,12'h5FF,8'h02,8'h40,8'h02,8'h42,2'h0},
          '{16'h1260,1'h0,4'h5,12'h000,12'hF60,8'h01,8'h80,8'h01,8'h81,2'h2},
          '{16'h105F,1'h0,4'h5,12'h000,12'h05F,8'h01,8'h81,8'h81,8'h81,2'h2},
          '{16'h125F,1'h1,4'h5,12'h200,12'h25F,8'h30,8'h0C,8'h30,8'h3C,2'h0},
          '{16'h1260,1'h1,4'h5,12'h200,12'hF60,8'h10,8'h01,8'h10,8'h11,2'h0},
          '{16'h1310,1'h1,4'h2,12'h200,12'h210,8'h0F,8'h70,8'h0F,8'h7F,2'h0}};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        foreach (rows[i]) begin
            r = rows[i];
            bus(1'h1, IORU_ADR_CTRL, {31'h0, r.ext});
            bus(1'h1, IORU_ADR_WREG, {24'h0, r.w});
            bus(1'h1, IORU_ADR_BANK, {28'h0, r.bank});
            bus(1'h1, IORU_ADR_FSR2, {20'h0, r.fsr});
            bus(1'h1, IORU_ADR_MEMADR, {20'h0, r.ea});
            bus(1'h1, IORU_ADR_MEMDAT, {24'h0, r.mv});
            bus(1'h1, IORU_ADR_INSTR, {16'h0, r.ins});
            wait_idle();
            chk({30'h0, q[1:0]}, {30'h0, r.nz});
            bus(1'h0, IORU_ADR_WREG, 32'h0);
            chk(q, {24'h0, r.ew});
            bus(1'h0, IORU_ADR_MEMDAT, 32'h0);
            chk(q, {24'h0, r.em});
        end
        // W write during a file-destined run must be dropped
        bus(1'h1, IORU_ADR_WREG, 32'h80);
        bus(1'h1, IORU_ADR_INSTR, 32'h1310);
        bus(1'h1, IORU_ADR_WREG, 32'h55);
        wait_idle();
        bus(1'h0, IORU_ADR_WREG, 32'h0);
        chk(q, 32'h80);
        bus(1'h0, IORU_ADR_MEMDAT, 32'h0);
        chk(q, 32'hFF);
        bus(1'h1, IORU_ADR_INSTR, 32'hFFFF);
        wait_idle();
        chk({31'h0, q[3]}, 32'h1);
        bus(1'h0, IORU_ADR_WREG, 32'h0);
        chk(q, 32'h80);
        // Byte lanes: lane 0 alone writes W and the low INSTR byte only
        bsel = 4'h1;
        bus(1'h1, IORU_ADR_INSTR, 32'h0955);
        bus(1'h1, IORU_ADR_WREG, 32'h12);
        bsel = 4'h2;
        bus(1'h1, IORU_ADR_WREG, 32'h34);
        bsel = 4'hF;
        bus(1'h0, IORU_ADR_WREG, 32'h0);
        chk(q, 32'h12);
        bus(1'h0, IORU_ADR_INSTR, 32'h0);
        chk(q, 32'hFF55);
        bus(1'h1, 8'h20, 32'hFF);
        bus(1'h0, 8'h20, 32'h0);
        chk(q, 32'h0);
        // Second reset, taken while idle, clears the registers at 0x00 through 0x18
        @(posedge clk_i);
        rst_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        for (int k = 0; k < 7; k++) begin
            bus(1'h0, 8'(k * 4), 32'h0);
            chk(q, 32'h0);
        end
        give_verdict();
    end
endmodule
